// ### inc/port_cde_pkg.sv
// constants, types and decode helper for the port c/d/e pin control block
package port_cde_pkg;

	// ----------------------------------------------------------------
	// bus and pin geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4; // register address width
	localparam int DATA_W = 16; // register data width
	localparam int PC_PINS = 21; // port c pins 20..0
	localparam int PD_PINS = 8; // port d pins 7..0
	localparam int PE_PINS = 25; // port e pins 24..0

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] OFF_C_DIR_HI = 4'h0;
	localparam logic [3:0] OFF_C_DIR_LO = 4'h1;
	localparam logic [3:0] OFF_D_DIR_LO = 4'h2;
	localparam logic [3:0] OFF_D_FUNC_LO2 = 4'h3;
	localparam logic [3:0] OFF_E_DIR_HI = 4'h4;
	localparam logic [3:0] OFF_E_DIR_LO = 4'h5;
	localparam logic [3:0] OFF_E_FUNC_HI1 = 4'h6;

	// ----------------------------------------------------------------
	// writable bit masks; other bits are reserved and read zero
	// ----------------------------------------------------------------
	localparam logic [15:0] MASK_C_DIR_HI = 16'h001f;
	localparam logic [15:0] MASK_C_DIR_LO = 16'hffff;
	localparam logic [15:0] MASK_D_DIR_LO = 16'h00ff;
	localparam logic [15:0] MASK_D_FUNC_LO2 = 16'hfff5;
	localparam logic [15:0] MASK_E_DIR_HI = 16'h01ff;
	localparam logic [15:0] MASK_E_DIR_LO = 16'hffff;
	localparam logic [15:0] MASK_E_FUNC_HI1 = 16'h0003;

	// ----------------------------------------------------------------
	// reset values and counts
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_REG = 16'h0000; // all registers after reset
	localparam logic [2:0] STRAP_SETTLE = 3'h4; // cycles before strap is trusted

	// ----------------------------------------------------------------
	// select field codes
	// ----------------------------------------------------------------
	localparam logic [1:0] MD_GPIO = 2'h0;
	localparam logic [1:0] MD_FUNC1 = 2'h1;
	localparam logic [1:0] MD_FUNC2 = 2'h2;

	typedef enum logic [1:0] {PIN_GPIO, PIN_FUNC1, PIN_FUNC2} pin_mode_e;
	typedef enum logic {BOOT_SETTLE, BOOT_DONE} boot_state_e;

	// register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// signals from the serial unit toward the pins
	typedef struct packed {
		logic s1_clock;
		logic s1_clock_oe;
		logic s1_transmit;
		logic s2_clock;
		logic s2_clock_oe;
		logic s2_transmit;
	} serial_drive_s;

	// pin levels handed to the serial unit
	typedef struct packed {
		logic s1_clock;
		logic s1_receive;
		logic s1_clear_to_send;
		logic s2_clock;
		logic s2_receive;
	} serial_sense_s;

	// select code to pin mode; the prohibited code falls back to general i/o
	function automatic pin_mode_e decode_mode(input logic [1:0] code);
		pin_mode_e m;
		m = PIN_GPIO;
		case (code)
			MD_FUNC1: m = PIN_FUNC1;
			MD_FUNC2: m = PIN_FUNC2;
			default: m = PIN_GPIO;
		endcase
		return m;
	endfunction

endpackage

// ### hdl/port_cde_pinctl.sv
// direction and function select registers and pin routing for ports c, d and e
//
// Summary of operation
// - direction 1 drives output, 0 makes input
// - port c direction applies only as gpio
// - port c high bits 15..5 read zero
// - all direction registers reset to zero
// - port d direction bits 7..0, upper zero
// - pin d7 select: gpio, interrupt 7, serial2 clock
// - pin d6 select: gpio, interrupt 6, serial2 receive
// - pin d5 select: gpio, interrupt 5, serial2 transmit
// - pin d4 select: gpio, interrupt 4, serial1 clock
// - pin d3 select: gpio, interrupt 3, serial1 receive
// - pin d2 select: gpio, interrupt 2, serial1 transmit
// - bit 2 selects pin d1 interrupt 1
// - bit 0 selects pin d0 interrupt 0
// - port d function bits 3,1 read zero
// - port e direction applies only as gpio
// - port e high direction bits 15..9 zero
// - port e function high1 bits 15..2 zero
// - pin e24 select: gpio, host data15, serial1 cts
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/10ps
module port_cde_pinctl (
	input logic mclk_in, // 25 mhz system clock
	input logic sys_rst_in, // asynchronous reset, active high
	input port_cde_pkg::reg_req_s reg_req_in, // register port request
	output logic [15:0] reg_rdata_out, // read data, cycle after read strobe
	input logic host_boot_in, // boot strap pin, 1 = host-interface boot
	input logic [20:0] gpio_c_data_in, // port c output data
	input logic [7:0] gpio_d_data_in, // port d output data
	input logic [24:0] gpio_e_data_in, // port e output data
	input logic [20:0] pc_alt_sel_in, // port c pins owned by other functions
	input logic [20:0] pc_alt_out_in, // their output values
	input logic [20:0] pc_alt_oe_in, // their output enables
	input logic [23:0] pe_alt_sel_in, // port e pins 23..0 owned by other functions
	input logic [23:0] pe_alt_out_in, // their output values
	input logic [23:0] pe_alt_oe_in, // their output enables
	input port_cde_pkg::serial_drive_s serial_drive_in, // serial unit drive
	input logic host_port_data_bit15_in, // host unit data bit 15 out
	input logic host_port_data_bit15_oe_in, // host unit data bit 15 enable
	input logic [20:0] pin_c_in, // port c pad levels
	input logic [7:0] pin_d_in, // port d pad levels
	input logic [24:0] pin_e_in, // port e pad levels
	output logic [20:0] pin_c_out, // port c pad drive values
	output logic [20:0] pin_c_oe_out, // port c pad enables
	output logic [7:0] pin_d_out, // port d pad drive values
	output logic [7:0] pin_d_oe_out, // port d pad enables
	output logic [24:0] pin_e_out, // port e pad drive values
	output logic [24:0] pin_e_oe_out, // port e pad enables
	output logic [20:0] level_c_out, // filtered port c levels
	output logic [7:0] level_d_out, // filtered port d levels
	output logic [24:0] level_e_out, // filtered port e levels
	output logic [7:0] ext_interrupt_req_out, // interrupt request levels
	output port_cde_pkg::serial_sense_s serial_sense_out, // levels to serial unit
	output logic host_port_data_bit15_out // pin level to host unit
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] port_c_direction_high; // pins 20..16
	logic [15:0] port_c_direction_low; // pins 15..0
	logic [15:0] port_d_direction_low; // pins 7..0
	logic [15:0] port_d_function_low2; // port d select fields
	logic [15:0] port_e_direction_high; // pins 24..16
	logic [15:0] port_e_direction_low; // pins 15..0
	logic [15:0] port_e_function_high1; // pin 24 select field

	localparam int SYNC_W = 55; // all pads plus the boot strap
	logic [SYNC_W-1:0] sync_a; // first stage, read only by sync_b
	logic [SYNC_W-1:0] sync_b; // second stage
	logic [SYNC_W-1:0] sync_c; // third stage
	logic [SYNC_W-1:0] level; // accepted levels
	logic strap_level; // filtered boot strap

	port_cde_pkg::boot_state_e boot_state; // strap capture state
	logic [2:0] boot_cnt; // settle counter

	logic wr_c_hi, wr_c_lo, wr_d_dir, wr_d_fn, wr_e_hi, wr_e_lo, wr_e_fn; // write decodes
	logic [15:0] next_rdata; // read mux

	logic [7:0] next_d_out, next_d_oe, next_irq; // port d routing
	logic [7:0] d_ser_sel; // port d pin on serial function
	logic [7:0] d_ser_out, d_ser_oe; // serial drive per port d pin
	logic [20:0] c_dir; // port c direction vector
	logic [24:0] e_dir; // port e direction vector
	logic [20:0] next_c_out, next_c_oe; // port c routing
	logic [24:0] next_e_out, next_e_oe; // port e routing
	port_cde_pkg::pin_mode_e e24_mode; // pin e24 mode
	port_cde_pkg::serial_sense_s next_sense; // serial levels
	logic next_host15; // host data level

	// ----------------------------------------------------------------
	// pad synchronisers
	// ----------------------------------------------------------------
	// three stages; a change counts once stages two and three agree
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync_a <= '0;
			sync_b <= '0;
			sync_c <= '0;
			level <= '0;
		end else begin
			sync_a <= {host_boot_in, pin_e_in, pin_d_in, pin_c_in};
			sync_b <= sync_a;
			sync_c <= sync_b;
			level <= (sync_b & sync_c) | (level & (sync_b ^ sync_c));
		end
	end

	assign strap_level = level[54];
	assign level_c_out = level[20:0];
	assign level_d_out = level[28:21];
	assign level_e_out = level[53:29];

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	assign wr_c_hi = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_C_DIR_HI;
	assign wr_c_lo = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_C_DIR_LO;
	assign wr_d_dir = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_D_DIR_LO;
	assign wr_d_fn = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_D_FUNC_LO2;
	assign wr_e_hi = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_E_DIR_HI;
	assign wr_e_lo = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_E_DIR_LO;
	assign wr_e_fn = reg_req_in.wr && reg_req_in.addr == port_cde_pkg::OFF_E_FUNC_HI1;

	// direction registers; reserved bits never store
	// cleared to inputs
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_c_direction_high <= port_cde_pkg::RST_REG;
			port_c_direction_low <= port_cde_pkg::RST_REG;
			port_d_direction_low <= port_cde_pkg::RST_REG;
			port_e_direction_high <= port_cde_pkg::RST_REG;
			port_e_direction_low <= port_cde_pkg::RST_REG;
		end else begin
			if (wr_c_hi) begin
				port_c_direction_high <= reg_req_in.wdata & port_cde_pkg::MASK_C_DIR_HI;
			end
			if (wr_c_lo) begin
				port_c_direction_low <= reg_req_in.wdata & port_cde_pkg::MASK_C_DIR_LO;
			end
			if (wr_d_dir) begin
				port_d_direction_low <= reg_req_in.wdata & port_cde_pkg::MASK_D_DIR_LO;
			end
			if (wr_e_hi) begin
				port_e_direction_high <= reg_req_in.wdata & port_cde_pkg::MASK_E_DIR_HI;
			end
			if (wr_e_lo) begin
				port_e_direction_low <= reg_req_in.wdata & port_cde_pkg::MASK_E_DIR_LO;
			end
		end
	end

	// port d select fields
	// bits 3 and 1 masked
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_d_function_low2 <= port_cde_pkg::RST_REG;
		end else if (wr_d_fn) begin
			port_d_function_low2 <= reg_req_in.wdata & port_cde_pkg::MASK_D_FUNC_LO2;
		end
	end

	// strap settle and capture; a software write ends the wait
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			boot_state <= port_cde_pkg::BOOT_SETTLE;
			boot_cnt <= '0;
		end else begin
			case (boot_state)
				port_cde_pkg::BOOT_SETTLE: begin
					boot_cnt <= boot_cnt + 3'h1;
					if (wr_e_fn || boot_cnt == port_cde_pkg::STRAP_SETTLE) begin
						boot_state <= port_cde_pkg::BOOT_DONE;
					end
				end
				port_cde_pkg::BOOT_DONE: begin
					boot_cnt <= boot_cnt;
				end
				default: begin
					boot_state <= port_cde_pkg::BOOT_DONE;
				end
			endcase
		end
	end

	// pin e24 select field; software write wins over strap load
	// bits 15..2 masked
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			port_e_function_high1 <= port_cde_pkg::RST_REG;
		end else if (wr_e_fn) begin
			port_e_function_high1 <= reg_req_in.wdata & port_cde_pkg::MASK_E_FUNC_HI1;
		end else if (boot_state == port_cde_pkg::BOOT_SETTLE &&
				boot_cnt == port_cde_pkg::STRAP_SETTLE) begin
			port_e_function_high1 <= {15'h0000, strap_level};
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 16'h0000;
		case (reg_req_in.addr)
			port_cde_pkg::OFF_C_DIR_HI: next_rdata = port_c_direction_high;
			port_cde_pkg::OFF_C_DIR_LO: next_rdata = port_c_direction_low;
			port_cde_pkg::OFF_D_DIR_LO: next_rdata = port_d_direction_low;
			port_cde_pkg::OFF_D_FUNC_LO2: next_rdata = port_d_function_low2;
			port_cde_pkg::OFF_E_DIR_HI: next_rdata = port_e_direction_high;
			port_cde_pkg::OFF_E_DIR_LO: next_rdata = port_e_direction_low;
			port_cde_pkg::OFF_E_FUNC_HI1: next_rdata = port_e_function_high1;
			default: next_rdata = 16'h0000;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else begin
			reg_rdata_out <= reg_req_in.rd ? next_rdata : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// port d routing
	// ----------------------------------------------------------------
	assign d_ser_out = {serial_drive_in.s2_clock, 1'b0, serial_drive_in.s2_transmit,
		serial_drive_in.s1_clock, 1'b0, serial_drive_in.s1_transmit, 2'b00};
	assign d_ser_oe = {serial_drive_in.s2_clock_oe, 1'b0, 1'b1,
		serial_drive_in.s1_clock_oe, 1'b0, 1'b1, 2'b00};

	genvar gi;
	generate
		for (gi = 0; gi < port_cde_pkg::PD_PINS; gi++) begin : g_pd
			// per pin: gpio, interrupt input, or serial signal on pins 7..2 (pins 1 and 0 cannot select it)
			always_comb begin
				next_d_out[gi] = gpio_d_data_in[gi];
				next_d_oe[gi] = port_d_direction_low[gi];
				next_irq[gi] = 1'b0;
				d_ser_sel[gi] = 1'b0;
				case (port_cde_pkg::decode_mode(port_d_function_low2[2*gi+1 -: 2]))
					port_cde_pkg::PIN_FUNC1: begin
						next_d_out[gi] = 1'b0;
						next_d_oe[gi] = 1'b0;
						next_irq[gi] = level_d_out[gi];
					end
					port_cde_pkg::PIN_FUNC2: begin
						next_d_out[gi] = d_ser_out[gi];
						next_d_oe[gi] = d_ser_oe[gi];
						d_ser_sel[gi] = 1'b1;
					end
					default: begin
						next_d_oe[gi] = port_d_direction_low[gi];
					end
				endcase
			end

			// interrupt function keeps pad as input and passes its level to the request
			property p_irq_pin;
				@(posedge mclk_in) disable iff (sys_rst_in)
				port_d_function_low2[2*gi+1 -: 2] == port_cde_pkg::MD_FUNC1
				|=> !pin_d_oe_out[gi] && ext_interrupt_req_out[gi] == $past(level_d_out[gi]);
			endproperty
			a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not routed");
		end
	endgenerate

	// ----------------------------------------------------------------
	// port c and port e routing
	// ----------------------------------------------------------------
	assign c_dir = {port_c_direction_high[4:0], port_c_direction_low};
	assign e_dir = {port_e_direction_high[8:0], port_e_direction_low};
	assign e24_mode = port_cde_pkg::decode_mode(port_e_function_high1[1:0]);

	// c direction only where pin is gpio
	assign next_c_out = (pc_alt_sel_in & pc_alt_out_in) | (~pc_alt_sel_in & gpio_c_data_in);
	assign next_c_oe = (pc_alt_sel_in & pc_alt_oe_in) | (~pc_alt_sel_in & c_dir);

	// e direction only where pin is gpio
	always_comb begin
		next_e_out[23:0] = (pe_alt_sel_in & pe_alt_out_in) | (~pe_alt_sel_in & gpio_e_data_in[23:0]);
		next_e_oe[23:0] = (pe_alt_sel_in & pe_alt_oe_in) | (~pe_alt_sel_in & e_dir[23:0]);
		next_host15 = 1'b0;
		next_sense.s1_clear_to_send = 1'b0;
		case (e24_mode)
			port_cde_pkg::PIN_FUNC1: begin
				next_e_out[24] = host_port_data_bit15_in;
				next_e_oe[24] = host_port_data_bit15_oe_in;
				next_host15 = level_e_out[24];
			end
			port_cde_pkg::PIN_FUNC2: begin
				next_e_out[24] = 1'b0;
				next_e_oe[24] = 1'b0;
				next_sense.s1_clear_to_send = level_e_out[24];
			end
			default: begin
				next_e_out[24] = gpio_e_data_in[24];
				next_e_oe[24] = e_dir[24];
			end
		endcase
		next_sense.s1_clock = d_ser_sel[4] & level_d_out[4];
		next_sense.s1_receive = d_ser_sel[3] & level_d_out[3];
		next_sense.s2_clock = d_ser_sel[7] & level_d_out[7];
		next_sense.s2_receive = d_ser_sel[6] & level_d_out[6];
	end

	// registered pad and peripheral outputs
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pin_c_out <= '0;
			pin_c_oe_out <= '0;
			pin_d_out <= '0;
			pin_d_oe_out <= '0;
			pin_e_out <= '0;
			pin_e_oe_out <= '0;
			ext_interrupt_req_out <= '0;
			serial_sense_out <= '0;
			host_port_data_bit15_out <= 1'b0;
		end else begin
			pin_c_out <= next_c_out;
			pin_c_oe_out <= next_c_oe;
			pin_d_out <= next_d_out;
			pin_d_oe_out <= next_d_oe;
			pin_e_out <= next_e_out;
			pin_e_oe_out <= next_e_oe;
			ext_interrupt_req_out <= next_irq;
			serial_sense_out <= next_sense;
			host_port_data_bit15_out <= next_host15;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic first_cycle; // high in the first cycle after reset release
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			first_cycle <= 1'b1;
		end else begin
			first_cycle <= 1'b0;
		end
	end

	property p_dir_out;
		@(posedge mclk_in) disable iff (sys_rst_in)
		!pc_alt_sel_in[3] |=> pin_c_oe_out[3] == $past(port_c_direction_low[3]);
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("gpio enable not from direction");

	property p_c_alt;
		@(posedge mclk_in) disable iff (sys_rst_in)
		pc_alt_sel_in[20] |=> pin_c_oe_out[20] == $past(pc_alt_oe_in[20]);
	endproperty
	a_c_alt: assert property (p_c_alt) else $error("port c alternate enable lost");

	property p_c_hi_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		reg_req_in.rd && reg_req_in.addr == port_cde_pkg::OFF_C_DIR_HI
		|=> reg_rdata_out[15:5] == 11'h000;
	endproperty
	a_c_hi_read: assert property (p_c_hi_read) else $error("port c high reserved nonzero");

	property p_reset_zero;
		@(posedge mclk_in) disable iff (sys_rst_in)
		first_cycle |-> c_dir == '0 && e_dir == '0 && port_d_direction_low == 16'h0000;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("direction not zero at reset");

	property p_d_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		reg_req_in.rd && reg_req_in.addr == port_cde_pkg::OFF_D_DIR_LO
		|=> reg_rdata_out[15:8] == 8'h00;
	endproperty
	a_d_read: assert property (p_d_read) else $error("port d upper byte nonzero");

	property p_d7_serial;
		@(posedge mclk_in) disable iff (sys_rst_in)
		port_d_function_low2[15:14] == port_cde_pkg::MD_FUNC2
		|=> pin_d_oe_out[7] == $past(serial_drive_in.s2_clock_oe);
	endproperty
	a_d7_serial: assert property (p_d7_serial) else $error("serial2 clock not routed");

	property p_d5_tx;
		@(posedge mclk_in) disable iff (sys_rst_in)
		port_d_function_low2[11:10] == port_cde_pkg::MD_FUNC2
		|=> pin_d_oe_out[5] && pin_d_out[5] == $past(serial_drive_in.s2_transmit);
	endproperty
	a_d5_tx: assert property (p_d5_tx) else $error("serial2 transmit not routed");

	property p_d_fn_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		reg_req_in.rd && reg_req_in.addr == port_cde_pkg::OFF_D_FUNC_LO2
		|=> !reg_rdata_out[3] && !reg_rdata_out[1];
	endproperty
	a_d_fn_read: assert property (p_d_fn_read) else $error("port d reserved bit nonzero");

	property p_e_reserved;
		@(posedge mclk_in) disable iff (sys_rst_in)
		port_e_direction_high[15:9] == 7'h00 && port_e_function_high1[15:2] == 14'h0000;
	endproperty
	a_e_reserved: assert property (p_e_reserved) else $error("port e reserved bit set");

	property p_e24_cts;
		@(posedge mclk_in) disable iff (sys_rst_in)
		port_e_function_high1[1:0] == port_cde_pkg::MD_FUNC2
		|=> !pin_e_oe_out[24] ##0 serial_sense_out.s1_clear_to_send == $past(level_e_out[24]);
	endproperty
	a_e24_cts: assert property (p_e24_cts) else $error("clear to send not routed");

	property p_boot_preset;
		@(posedge mclk_in) disable iff (sys_rst_in)
		boot_state == port_cde_pkg::BOOT_SETTLE && boot_cnt == port_cde_pkg::STRAP_SETTLE
		&& !wr_e_fn |=> port_e_function_high1 == {15'h0000, $past(strap_level)};
	endproperty
	a_boot_preset: assert property (p_boot_preset) else $error("boot preset wrong");

	c_host_boot: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		boot_state == port_cde_pkg::BOOT_DONE && port_e_function_high1[0]);
	c_irq_seen: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		ext_interrupt_req_out[7]);
	c_serial_tx: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		d_ser_sel[2] && pin_d_oe_out[2]);

endmodule

// ### tb/port_cde_direction_and_function_select_test.sv
// self-checking bench for the port c/d/e pin control block
`timescale 1ns/10ps
module port_cde_direction_and_function_select_test;
	// --------------------
	// signals
	// --------------------
	logic clk = 1'b0; // system clock
	logic rst = 1'b1; // reset, active high
	port_cde_pkg::reg_req_s req = '0; // register request
	port_cde_pkg::serial_drive_s sd = '0; // serial unit drive
	port_cde_pkg::serial_sense_s ss; // serial unit sense
	logic boot = 1'b0, hd = 1'b0, hoe = 1'b0, hin;
	logic [20:0] gc = '0, cs = '0, co = '0, coe = '0, pc = '0, pco, pcoe, lc, yo, ye;
	logic [23:0] es = '0, eo = '0, eoe = '0;
	logic [24:0] ge = '0, pe = '0, peo, peoe, le, xo, xe;
	logic [7:0] gd = '0, pd = '0, pdo, pdoe, ld, irq;
	logic [15:0] rdata;
	logic [15:0] regs [7]; // expected register contents
	logic [15:0] msk [7] = '{16'h001f, 16'hffff, 16'h00ff, 16'hfff5, 16'h01ff, 16'hffff, 16'h0003};
	logic [15:0] fnp [4] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff}; // select patterns
	logic [27:0] ed; // expected port d view
	logic [1:0] c24; // pin e24 select
	int fails = 0, n_checks = 0;

	port_cde_pinctl uut (.mclk_in(clk), .sys_rst_in(rst), .reg_req_in(req), .reg_rdata_out(rdata),
		.host_boot_in(boot), .gpio_c_data_in(gc), .gpio_d_data_in(gd), .gpio_e_data_in(ge),
		.pc_alt_sel_in(cs), .pc_alt_out_in(co), .pc_alt_oe_in(coe), .pe_alt_sel_in(es),
		.pe_alt_out_in(eo), .pe_alt_oe_in(eoe), .serial_drive_in(sd),
		.host_port_data_bit15_in(hd), .host_port_data_bit15_oe_in(hoe), .pin_c_in(pc),
		.pin_d_in(pd), .pin_e_in(pe), .pin_c_out(pco), .pin_c_oe_out(pcoe), .pin_d_out(pdo),
		.pin_d_oe_out(pdoe), .pin_e_out(peo), .pin_e_oe_out(peoe), .level_c_out(lc),
		.level_d_out(ld), .level_e_out(le), .ext_interrupt_req_out(irq),
		.serial_sense_out(ss), .host_port_data_bit15_out(hin));

	// 40 ns clock
	initial forever #20 clk = ~clk;

	// --------------------
	// helpers
	// --------------------
	// wide enough for the 54-bit level view
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one-cycle write, remembers masked value
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		if (a < 4'h7) regs[a] = d & msk[a];
		@(posedge clk);
		req <= '0;
	endtask

	// reads all registers plus one unmapped address
	task automatic rd_all();
		for (int a = 0; a < 8; a++) begin
			@(posedge clk);
			req <= '{(a == 7) ? 4'hf : a[3:0], 16'h0, 1'b0, 1'b1};
			@(posedge clk);
			req <= '0;
			#1 chk("reg", rdata, (a < 7) ? regs[a] : 16'h0);
		end
	endtask

	// port d routing: {sense4, irq, oe, out}
	function automatic logic [27:0] exp_d(input logic [15:0] fn, input logic [7:0] dir, dat, pad,
		input port_cde_pkg::serial_drive_s s);
		logic [7:0] oe, o, q;
		logic [1:0] c;
		oe = dir;
		o = dat;
		q = '0;
		for (int i = 0; i < 8; i++) begin
			c = (i < 2) ? {1'b0, fn[2*i]} : fn[2*i+:2];
			if (c == 2'h1) begin
				oe[i] = 1'b0;
				q[i] = pad[i];
			end else if (c == 2'h2) begin
				oe[i] = (i == 7) ? s.s2_clock_oe : (i == 4) ? s.s1_clock_oe : (i == 5 || i == 2);
				o[i] = (i == 7) ? s.s2_clock : (i == 4) ? s.s1_clock : s.s1_transmit;
				if (i == 5) o[i] = s.s2_transmit;
			end
		end
		return {fn[9:8] == 2'h2 && pad[4], fn[7:6] == 2'h2 && pad[3],
			fn[15:14] == 2'h2 && pad[7], fn[13:12] == 2'h2 && pad[6], q, oe, o & oe};
	endfunction

	// --------------------
	// sequence
	// --------------------
	initial begin
		void'($urandom(32'he7ca));
		for (int a = 0; a < 7; a++) regs[a] = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_all();
		for (int k = 0; k < 8; k++) begin
			@(posedge clk);
			{gc, cs, co} <= 63'({$urandom, $urandom});
			{coe, pc, gd, pd} <= 58'({$urandom, $urandom});
			{ge, pe} <= 50'({$urandom, $urandom});
			{es, eo} <= 48'({$urandom, $urandom});
			{eoe, sd, hd, hoe} <= 32'($urandom);
			for (int a = 0; a < 6; a++) wr(a[3:0], (a == 3 && k < 4) ? fnp[k] : 16'($urandom));
			wr(4'h6, {14'($urandom), k[1:0]});
			wr(4'h7 + 4'(k), 16'($urandom));
			repeat (8) @(posedge clk);
			#1 rd_all();
			c24 = regs[6][1:0];
			ye = cs & coe | ~cs & {regs[0][4:0], regs[1]};
			yo = (cs & co | ~cs & gc) & ye;
			xe = {c24 == 2'h1 ? hoe : c24 != 2'h2 && regs[4][8],
				es & eoe | ~es & {regs[4][7:0], regs[5]}};
			xo = {c24 == 2'h1 ? hd : ge[24], es & eo | ~es & ge[23:0]} & xe;
			ed = exp_d(regs[3], regs[2][7:0], gd, pd, sd);
			chk("c_oe", pcoe, ye);
			chk("c_out", pco & ye, yo);
			chk("e_oe", peoe, xe);
			chk("e_out", peo & xe, xo);
			chk("d_oe", pdoe, ed[15:8]);
			chk("d_out", pdo & ed[15:8], ed[7:0]);
			chk("irq", irq, ed[23:16]);
			chk("sense", {ss.s1_clock, ss.s1_receive, ss.s2_clock, ss.s2_receive}, ed[27:24]);
			chk("cts", ss.s1_clear_to_send, c24 == 2'h2 && pe[24]);
			chk("host", hin, c24 == 2'h1 && pe[24]);
			chk("level", {lc, ld, le}, {pc, pd, pe});
		end
		@(posedge clk);
		boot <= 1'b1;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 7; a++) regs[a] = '0;
		regs[6] = 16'h0001;
		repeat (10) @(posedge clk);
		rd_all();
		conclude();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		conclude();
	end
endmodule
